/* File: src/ccsf_pkg.sv */
package ccsf_pkg;
    // ==================================
    // widths
    localparam int DW = 8;
    localparam int NREG = 32;
    localparam int RAW = 5;
    localparam int OP_W = 5;
    localparam int BIT_W = 3;
    localparam int IOA_W = 6;
    localparam int PSEL_W = 2;
    localparam int WORD_LSB = 2;
    localparam int H_SRC = 3;
    // ==================================
    // condition flag positions
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_S = 4;
    localparam int F_H = 5;
    localparam int F_T = 6;
    localparam int F_I = 7;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // ==================================
    // register map, byte addresses
    localparam logic [7:0] A_FLAGS = 8'h00;
    localparam logic [7:0] A_INSTR = 8'h04;
    localparam logic [7:0] A_PEND = 8'h08;
    localparam logic [7:0] A_IEN = 8'h0c;
    localparam logic [7:0] A_SP = 8'h10;
    localparam logic [7:0] A_PC = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_SPM = 8'h1c;
    localparam logic [7:0] A_RF = 8'h80;
    // ==================================
    // data space windows and pointer pairs
    localparam logic [15:0] RF_LAST = 16'h001f;
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] IO_LAST = 16'h005f;
    localparam logic [15:0] EXT_BASE = 16'h0060;
    localparam logic [15:0] EXT_LAST = 16'h00ff;
    localparam logic [4:0] PTR_X = 5'h1a;
    localparam logic [4:0] PTR_Z = 5'h1e;
    localparam logic [4:0] SPM_SRC = 5'h00;
    // ==================================
    // instruction word fields
    localparam int OP_LSB = 0;
    localparam int RD_LSB = 5;
    localparam int RR_LSB = 10;
    localparam int IMM_LSB = 15;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
        OP_AND = 5'h04, OP_OR = 5'h05, OP_EOR = 5'h06, OP_LDI = 5'h07,
        OP_SUBI = 5'h08, OP_ANDI = 5'h09, OP_BST = 5'h0a, OP_BLD = 5'h0b,
        OP_SEI = 5'h0c, OP_CLI = 5'h0d, OP_RETURN_FROM_IRQ_INSTR = 5'h0e, OP_CALL = 5'h0f,
        OP_RET = 5'h10, OP_IN = 5'h11, OP_OUT = 5'h12, OP_LDP = 5'h13,
        OP_STP = 5'h14, OP_LDS = 5'h15, OP_STS = 5'h16, OP_SPM = 5'h17
    } ccsf_op_e;
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_WAIT2 = 2'b10
    } ccsf_st_e;

    function automatic logic two_word(input ccsf_op_e op);
        return op inside {OP_CALL, OP_LDS, OP_STS};
    endfunction

    function automatic logic [15:0] io_to_data(input logic [IOA_W-1:0] a);
        return IO_BASE + {10'h000, a};
    endfunction
endpackage

/* File: src/ccsf_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module ccsf_alu
    import ccsf_pkg::*;
(
    input wire ccsf_op_e op,
    input wire logic [DW-1:0] a,
    input wire logic [DW-1:0] b,
    input wire logic [DW-1:0] flags_in,
    output logic [DW-1:0] res,
    output logic [DW-1:0] flags_out
);
    localparam int M = DW - 1;
    logic [DW:0] sum;
    logic [DW-1:0] r;
    logic sub, arith, cin, half, ovf;

    // ==================================
    // result
    assign sub = op inside {OP_SUB, OP_SUBI};
    assign arith = sub | (op inside {OP_ADD, OP_ADC});
    assign cin = (op == OP_ADC) & flags_in[F_C];
    assign sum = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, cin};
    always_comb begin
        case (op)
            OP_AND, OP_ANDI: r = a & b;
            OP_OR: r = a | b;
            OP_EOR: r = a ^ b;
            default: r = sum[DW-1:0];
        endcase
    end
    assign res = r;

    // ==================================
    // flags
    assign half = sub ? (~a[H_SRC] & b[H_SRC]) | (b[H_SRC] & r[H_SRC]) | (r[H_SRC] & ~a[H_SRC])
                      : (a[H_SRC] & b[H_SRC]) | (b[H_SRC] & ~r[H_SRC]) | (~r[H_SRC] & a[H_SRC]);
    assign ovf = sub ? (a[M] & ~b[M] & ~r[M]) | (~a[M] & b[M] & r[M])
                     : (a[M] & b[M] & ~r[M]) | (~a[M] & ~b[M] & r[M]);
    always_comb begin
        flags_out = flags_in;
        flags_out[F_N] = r[M];
        flags_out[F_Z] = (r == '0);
        flags_out[F_V] = arith & ovf;
        flags_out[F_S] = r[M] ^ (arith & ovf);
        // logic ops leave carry and half carry alone
        if (arith) begin
            flags_out[F_H] = half;
            flags_out[F_C] = sum[DW];
        end
    end
endmodule
`default_nettype wire

/* File: src/ccsf_irq_pick.sv */
`timescale 1ns/1ps
`default_nettype none
module ccsf_irq_pick #(
    parameter int N = 8,
    parameter int IW = $clog2(N)
) (
    input wire logic [N-1:0] pend,
    input wire logic [N-1:0] en,
    input wire logic gie,
    output logic req,
    output logic [IW-1:0] idx
);
    logic [N-1:0] live;

    // ==================================
    // arbitration
    assign live = pend & en;
    assign req = gie & (|live);
    // lowest vector wins, scanned top down so the last hit stays
    always_comb begin
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (live[i]) begin
                idx = IW'(i);
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/ccsf_core.sv */
`timescale 1ns/1ps
`default_nettype none
module ccsf_core
    import ccsf_pkg::*;
#(
    parameter int NUM_IRQ = 8,
    parameter int VEC_WORDS = 1,
    parameter bit HAS_BOOT = 1'b1,
    parameter logic [15:0] BOOT_START = 16'h0c00,
    parameter int DMEM_DEPTH = 512,
    parameter logic [15:0] STACK_TOP = 16'h01ff
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_IRQ-1:0] irq_in,
    output logic irq_taken,
    output logic gie,
    output logic flash_wr_en,
    output logic [15:0] flash_wr_addr,
    output logic [15:0] flash_wr_data
);
    localparam int DAW = $clog2(DMEM_DEPTH);
    localparam int IW = $clog2(NUM_IRQ);

    // ==================================
    // state
    logic [DW-1:0] rf [NREG];
    logic [DW-1:0] dmem [DMEM_DEPTH];
    logic [DW-1:0] flags, next_flags;
    logic [15:0] pc, sp, next_pc, next_sp;
    logic [31:0] fw1;
    logic [15:0] fw2;
    logic fvalid;
    ccsf_st_e st;
    logic [NUM_IRQ-1:0] pend, ien, next_pend, set_mask, clr_mask;
    logic spm_blocked;
    logic [IW-1:0] last_irq;

    // ==================================
    // decode
    ccsf_op_e op;
    logic [RAW-1:0] rd, rr, ptr_lo, rf_wa;
    logic [BIT_W-1:0] bitn;
    logic [DW-1:0] imm, a, b, alu_res, alu_flags, ld_val, rf_wd;
    logic [15:0] dadr, ret_pc, pop_pc, vec, ptr_val;
    logic [DAW-1:0] sp_lo, sp_hi, sp_p1, sp_p2;
    logic exec, is_alu, use_imm, is_ld, is_st, in_rf, rf_we, push, pop, take;
    logic irq_req, spm_ok, spm_go, bst_bit;
    logic [IW-1:0] pick_idx;

    function automatic logic [15:0] ptr_at(input logic [RAW-1:0] lo);
        return {rf[lo + 5'h01], rf[lo]};
    endfunction

    assign op = ccsf_op_e'(fw1[OP_LSB +: OP_W]);
    assign rd = fw1[RD_LSB +: RAW];
    assign rr = fw1[RR_LSB +: RAW];
    assign imm = fw1[IMM_LSB +: DW];
    assign bitn = imm[BIT_W-1:0];
    assign exec = fvalid;
    assign a = rf[rd];
    assign bst_bit = a[bitn];
    assign use_imm = op inside {OP_SUBI, OP_ANDI};
    assign b = use_imm ? imm : rf[rr];
    assign is_alu = op inside {OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_EOR, OP_SUBI, OP_ANDI};
    assign is_ld = op inside {OP_IN, OP_LDP, OP_LDS};
    assign is_st = op inside {OP_OUT, OP_STP, OP_STS};
    assign ptr_lo = PTR_X + {2'b00, imm[PSEL_W-1:0], 1'b0};
    // direct i/o carries only six address bits, so it can never reach the extended window
    // pointer read kept in a process so that register writes retrigger it
    always_comb begin
        ptr_val = ptr_at(ptr_lo);
    end
    assign dadr = (op inside {OP_IN, OP_OUT}) ? io_to_data(imm[IOA_W-1:0])
                : (op inside {OP_LDS, OP_STS}) ? fw2 : ptr_val;
    assign in_rf = dadr <= RF_LAST;
    assign ld_val = in_rf ? rf[dadr[RAW-1:0]] : dmem[dadr[DAW-1:0]];

    ccsf_alu u_alu (
        .op(op),
        .a(a),
        .b(b),
        .flags_in(flags),
        .res(alu_res),
        .flags_out(alu_flags)
    );

    // ==================================
    // apb decode
    logic apb_setup, apb_wr, aligned, hit;
    logic wr_flags, wr_instr, wr_pend, wr_ien, wr_sp, wr_rf;
    logic [31:0] rdata;
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready & pwrite;
    assign aligned = paddr[WORD_LSB-1:0] == '0;
    assign hit = aligned & ((paddr <= A_SPM) | (paddr >= A_RF));
    assign wr_flags = apb_wr & (paddr == A_FLAGS);
    assign wr_instr = apb_wr & (paddr == A_INSTR);
    assign wr_pend = apb_wr & (paddr == A_PEND);
    assign wr_ien = apb_wr & (paddr == A_IEN);
    assign wr_sp = apb_wr & (paddr == A_SP);
    assign wr_rf = apb_wr & aligned & (paddr >= A_RF);

    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr)
            A_FLAGS: rdata[DW-1:0] = flags;
            A_INSTR: rdata = fw1;
            A_PEND: rdata[NUM_IRQ-1:0] = pend;
            A_IEN: rdata[NUM_IRQ-1:0] = ien;
            A_SP: rdata[15:0] = sp;
            A_PC: rdata[15:0] = pc;
            A_STAT: rdata = 32'({last_irq, spm_blocked, st == ST_WAIT2});
            A_SPM: rdata = {flash_wr_data, flash_wr_addr};
            default: begin
                if (paddr >= A_RF) begin
                    rdata[DW-1:0] = rf[paddr[WORD_LSB +: RAW]];
                end
            end
        endcase
    end

    // no wait state: data is latched in the setup cycle, ready shows in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~hit;
            if (apb_setup) begin
                prdata <= rdata;
            end
        end
    end

    // ==================================
    // fetch stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_RUN;
            fvalid <= 1'b0;
            fw1 <= 32'h0000_0000;
            fw2 <= 16'h0000;
        end else begin
            fvalid <= 1'b0;
            if (wr_instr) begin
                case (st)
                    ST_RUN: begin
                        fw1 <= pwdata;
                        if (two_word(ccsf_op_e'(pwdata[OP_LSB +: OP_W]))) begin
                            st <= ST_WAIT2;
                        end else begin
                            fvalid <= 1'b1;
                        end
                    end
                    ST_WAIT2: begin
                        fw2 <= pwdata[15:0];
                        fvalid <= 1'b1;
                        st <= ST_RUN;
                    end
                    default: st <= ST_RUN;
                endcase
            end
        end
    end

    // ==================================
    // register file write back
    always_comb begin
        rf_we = 1'b0;
        rf_wa = rd;
        rf_wd = alu_res;
        if (exec) begin
            if (is_alu) begin
                rf_we = 1'b1;
            end else if (op == OP_LDI) begin
                rf_we = 1'b1;
                rf_wd = imm;
            end else if (op == OP_BLD) begin
                rf_we = 1'b1;
                rf_wd = a;
                rf_wd[bitn] = flags[F_T];
            end else if (is_ld) begin
                rf_we = 1'b1;
                rf_wd = ld_val;
            end else if (is_st & in_rf) begin
                rf_we = 1'b1;
                rf_wa = dadr[RAW-1:0];
                rf_wd = a;
            end
        end
    end

    // a bus write that meets an executing write back is dropped
    always_ff @(posedge pclk) begin
        if (rf_we) begin
            rf[rf_wa] <= rf_wd;
        end else if (wr_rf) begin
            rf[paddr[WORD_LSB +: RAW]] <= pwdata[DW-1:0];
        end
    end

    // ==================================
    // stack and data memory
    assign push = take | (exec & (op == OP_CALL));
    assign pop = exec & (op inside {OP_RET, OP_RETURN_FROM_IRQ_INSTR});
    assign ret_pc = take ? pc : pc + 16'h0002;
    assign sp_lo = sp[DAW-1:0];
    assign sp_hi = DAW'(sp - 16'h0001);
    assign sp_p1 = DAW'(sp + 16'h0001);
    assign sp_p2 = DAW'(sp + 16'h0002);
    assign pop_pc = {dmem[sp_p1], dmem[sp_p2]};

    always_ff @(posedge pclk) begin
        if (push) begin
            dmem[sp_lo] <= ret_pc[7:0];
            dmem[sp_hi] <= ret_pc[15:8];
        end else if (exec & is_st & ~in_rf) begin
            dmem[dadr[DAW-1:0]] <= a;
        end
    end

    always_comb begin
        next_pc = pc;
        next_sp = sp;
        if (wr_sp) begin
            next_sp = pwdata[15:0];
        end
        if (take) begin
            next_pc = vec;
            next_sp = sp - 16'h0002;
        end else if (exec) begin
            next_pc = pc + (two_word(op) ? 16'h0002 : 16'h0001);
            if (op == OP_CALL) begin
                next_pc = fw2;
                next_sp = sp - 16'h0002;
            end else if (pop) begin
                next_pc = pop_pc;
                next_sp = sp + 16'h0002;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= 16'h0000;
            sp <= STACK_TOP;
        end else begin
            pc <= next_pc;
            sp <= next_sp;
        end
    end

    // ==================================
    // interrupts
    ccsf_irq_pick #(
        .N(NUM_IRQ),
        .IW(IW)
    ) u_pick (
        .pend(pend),
        .en(ien),
        .gie(flags[F_I]),
        .req(irq_req),
        .idx(pick_idx)
    );

    // only between instructions, never inside a two-word fetch
    assign take = irq_req & ~fvalid & (st == ST_RUN);
    assign vec = 16'((int'(pick_idx) + 1) * VEC_WORDS);
    assign clr_mask = take ? (NUM_IRQ'(1) << pick_idx) : '0;
    assign set_mask = irq_in | (wr_pend ? pwdata[NUM_IRQ-1:0] : '0);
    assign next_pend = (pend & ~clr_mask) | set_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= '0;
            ien <= '0;
            irq_taken <= 1'b0;
            last_irq <= '0;
        end else begin
            pend <= next_pend;
            irq_taken <= take;
            if (wr_ien) begin
                ien <= pwdata[NUM_IRQ-1:0];
            end
            if (take) begin
                last_irq <= pick_idx;
            end
        end
    end

    // ==================================
    // condition flags
    always_comb begin
        next_flags = flags;
        if (wr_flags) begin
            next_flags = pwdata[DW-1:0];
        end
        if (exec) begin
            case (op)
                OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_EOR, OP_SUBI, OP_ANDI:
                    next_flags = alu_flags;
                OP_SEI: next_flags[F_I] = 1'b1;
                OP_CLI: next_flags[F_I] = 1'b0;
                OP_RETURN_FROM_IRQ_INSTR: next_flags[F_I] = 1'b1;
                OP_BST: next_flags[F_T] = bst_bit;
                default: next_flags = next_flags;
            endcase
        end
        // entry touches only the enable; the program saves the rest
        if (take) begin
            next_flags[F_I] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    assign gie = flags[F_I];

    // ==================================
    // flash self-write
    assign spm_ok = !HAS_BOOT || (pc >= BOOT_START);
    assign spm_go = exec & (op == OP_SPM);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_wr_en <= 1'b0;
            flash_wr_addr <= 16'h0000;
            flash_wr_data <= 16'h0000;
            spm_blocked <= 1'b0;
        end else begin
            flash_wr_en <= spm_go & spm_ok;
            if (spm_go) begin
                spm_blocked <= ~spm_ok;
            end
            if (spm_go & spm_ok) begin
                flash_wr_addr <= ptr_at(PTR_Z);
                flash_wr_data <= ptr_at(SPM_SRC);
            end
        end
    end

    // ==================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_gie_gates: assert property (take |-> flags[F_I])
        else $error("interrupt taken with global enable clear");
    chk_gie_cleared: assert property (irq_taken |-> !flags[F_I])
        else $error("global enable not cleared on entry");
    chk_return_from_irq_instr_sets: assert property (exec && op == OP_RETURN_FROM_IRQ_INSTR |=> flags[F_I] && sp == $past(sp) + 16'h0002)
        else $error("return did not restore enable");
    chk_cli_clears: assert property (exec && op == OP_CLI |=> !flags[F_I])
        else $error("clear instruction left enable set");
    chk_bst_copy: assert property (exec && op == OP_BST |=> flags[F_T] == $past(bst_bit))
        else $error("bit store copy wrong");
    chk_sign_xor: assert property (exec && is_alu |=> flags[F_S] == (flags[F_N] ^ flags[F_V]))
        else $error("sign not negative xor overflow");
    chk_zero_flag: assert property (exec && is_alu |=> flags[F_Z] == ($past(alu_res) == 8'h00))
        else $error("zero flag disagrees with result");
    chk_one_cycle_wb: assert property (exec && is_alu |=> rf[$past(rd)] == $past(alu_res))
        else $error("result not written back in one clock");
    chk_irq_prio: assert property (take |-> (pend & ien & ~({NUM_IRQ{1'b1}} << pick_idx)) == '0)
        else $error("lower vector pending but not chosen");
    chk_spm_boot: assert property (flash_wr_en |-> !HAS_BOOT || $past(pc) >= BOOT_START)
        else $error("flash write outside boot section");
    chk_entry_push: assert property (take |=> sp == $past(sp) - 16'h0002 && pc == $past(vec))
        else $error("entry did not push and vector");

    cov_irq_taken: cover property (irq_taken);
    cov_call_ret: cover property (exec && op == OP_CALL ##[1:20] exec && op == OP_RET);
    cov_spm_blocked: cover property (spm_go && !spm_ok);
    cov_nested_sei: cover property (irq_taken ##[1:20] exec && op == OP_SEI);
endmodule
`default_nettype wire

/* File: dv/tb_cpu_core_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_core_status_flags;
    import ccsf_pkg::*;
    // ==================================
    // signals and instance
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, irq_in = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, irq_taken, gie, flash_wr_en;
    logic [15:0] flash_wr_addr, flash_wr_data, wr_a, wr_d;
    int fail_count = 0, n_compared = 0, n_taken = 0, n_wr = 0;
    always #10 pclk = ~pclk;
    ccsf_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_in(irq_in), .irq_taken(irq_taken), .gie(gie),
        .flash_wr_en(flash_wr_en), .flash_wr_addr(flash_wr_addr),
        .flash_wr_data(flash_wr_data));
    // pulses last one cycle, so count them at every edge
    always @(posedge pclk) begin
        if (irq_taken === 1'b1) n_taken++;
        if (flash_wr_en === 1'b1) begin
            n_wr++;
            wr_a = flash_wr_addr;
            wr_d = flash_wr_data;
        end
    end
    // ==================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // leading edge keeps release and next setup in separate time steps
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    function automatic logic [31:0] ins(ccsf_op_e op, logic [7:0] rd, rr, imm);
        return {9'h000, imm, rr[4:0], rd[4:0], op};
    endfunction
    function automatic logic [7:0] ra(logic [4:0] n);
        return A_RF + {1'b0, n, 2'b00};
    endfunction
    task automatic wait_taken(input int n);
        int i;
        for (i = 0; i < 20 && n_taken < n; i++) @(posedge pclk);
        chk(n_taken, n);
    endtask
    // ==================================
    // scenarios
    task automatic t_reset;
        rdc(A_FLAGS, 32'h0);
        chk(gie, 1'b0);
        rdc(A_SP, 32'h1ff);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        $display("done: reset");
    endtask
    task automatic t_alu;
        ccsf_op_e ops[9] = '{OP_ADD, OP_ADD, OP_SUB, OP_SUBI, OP_AND, OP_ADC, OP_OR, OP_EOR,
            OP_ANDI};
        logic [7:0] av[9] = '{8'h7f, 8'hff, 8'h00, 8'h10, 8'h80, 8'h0f, 8'h00, 8'haa, 8'hf0};
        logic [7:0] bv[9] = '{8'h01, 8'h01, 8'h01, 8'h10, 8'hff, 8'h00, 8'h00, 8'h55, 8'h3c};
        logic [7:0] fi[9] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h21, 8'h01, 8'h09, 8'h00, 8'h20};
        logic [7:0] rv[9] = '{8'h80, 8'h00, 8'hff, 8'h00, 8'h80, 8'h10, 8'h00, 8'hff, 8'h30};
        logic [7:0] fv[9] = '{8'h2c, 8'h63, 8'h35, 8'h02, 8'h35, 8'h20, 8'h03, 8'h14, 8'h20};
        for (int i = 0; i < 9; i++) begin
            wrr(ra(16), {24'h0, av[i]});
            wrr(ra(17), {24'h0, bv[i]});
            wrr(A_FLAGS, {24'h0, fi[i]});
            wrr(A_INSTR, ins(ops[i], 8'h10, 8'h11, bv[i]));
            rdc(ra(16), {24'h0, rv[i]});
            rdc(A_FLAGS, {24'h0, fv[i]});
        end
        $display("done: alu");
    endtask
    task automatic t_bits;
        wrr(ra(3), 32'h08);
        wrr(A_FLAGS, 32'h0);
        wrr(A_INSTR, ins(OP_BST, 8'h03, 8'h00, 8'h03));
        rdc(A_FLAGS, 32'h40);
        wrr(ra(4), 32'h0);
        wrr(A_INSTR, ins(OP_BLD, 8'h04, 8'h00, 8'h07));
        rdc(ra(4), 32'h80);
        wrr(A_INSTR, ins(OP_SEI, 8'h00, 8'h00, 8'h00));
        rdc(A_FLAGS, 32'hc0);
        chk(gie, 1'b1);
        wrr(A_INSTR, ins(OP_CLI, 8'h00, 8'h00, 8'h00));
        rdc(A_FLAGS, 32'h40);
        chk(gie, 1'b0);
        $display("done: bits");
    endtask
    task automatic t_irq;
        wrr(A_IEN, 32'hff);
        irq_in <= 8'h04;
        @(posedge pclk);
        irq_in <= 8'h00;
        wrr(A_PEND, 32'h02);
        repeat (5) @(posedge pclk);
        chk(n_taken, 0);
        wrr(A_FLAGS, 32'h83);
        wait_taken(1);
        rdc(A_FLAGS, 32'h03);
        apb(1'b0, A_STAT, 32'h0);
        chk(q[4:2], 3'd1);
        rdc(A_PC, 32'h2);
        rdc(A_SP, 32'h1fd);
        wrr(A_INSTR, ins(OP_RETURN_FROM_IRQ_INSTR, 8'h00, 8'h00, 8'h00));
        wait_taken(2);
        apb(1'b0, A_STAT, 32'h0);
        chk(q[4:2], 3'd2);
        rdc(A_FLAGS, 32'h03);
        rdc(A_PC, 32'h3);
        $display("done: irq");
    endtask
    task automatic t_spm;
        wrr(ra(0), 32'h34);
        wrr(ra(1), 32'h12);
        wrr(ra(30), 32'h78);
        wrr(ra(31), 32'h56);
        wrr(A_INSTR, ins(OP_SPM, 8'h00, 8'h00, 8'h00));
        apb(1'b0, A_STAT, 32'h0);
        chk(q[1], 1'b1);
        chk(n_wr, 0);
        wrr(A_INSTR, ins(OP_CALL, 8'h00, 8'h00, 8'h00));
        wrr(A_INSTR, 32'h0c00);
        rdc(A_PC, 32'h0c00);
        wrr(A_INSTR, ins(OP_SPM, 8'h00, 8'h00, 8'h00));
        repeat (3) @(posedge pclk);
        chk(n_wr, 1);
        chk(wr_a, 16'h5678);
        chk(wr_d, 16'h1234);
        wrr(A_INSTR, ins(OP_RET, 8'h00, 8'h00, 8'h00));
        rdc(A_PC, 32'h6);
        rdc(A_SP, 32'h1fd);
        $display("done: spm");
    endtask
    task automatic t_mem;
        wrr(A_INSTR, ins(OP_LDI, 8'h05, 8'h00, 8'h5a));
        rdc(ra(5), 32'h5a);
        wrr(A_INSTR, ins(OP_OUT, 8'h05, 8'h00, 8'h3f));
        wrr(A_INSTR, ins(OP_LDS, 8'h07, 8'h00, 8'h00));
        wrr(A_INSTR, 32'h005f);
        rdc(ra(7), 32'h5a);
        wrr(A_INSTR, ins(OP_IN, 8'h06, 8'h00, 8'h3f));
        rdc(ra(6), 32'h5a);
        wrr(A_INSTR, ins(OP_LDI, 8'h09, 8'h00, 8'hc3));
        wrr(A_INSTR, ins(OP_STS, 8'h09, 8'h00, 8'h00));
        wrr(A_INSTR, 32'h00a0);
        wrr(ra(26), 32'ha0);
        wrr(ra(27), 32'h00);
        wrr(A_INSTR, ins(OP_LDP, 8'h08, 8'h00, 8'h00));
        rdc(ra(8), 32'hc3);
        wrr(ra(28), 32'h02);
        wrr(ra(29), 32'h00);
        wrr(A_INSTR, ins(OP_STP, 8'h09, 8'h00, 8'h01));
        rdc(ra(2), 32'hc3);
        $display("done: mem");
    endtask
    // ==================================
    // run control
    task automatic summarize;
        $display("compared=%0d failures=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_alu;
        t_bits;
        t_irq;
        t_spm;
        t_mem;
        summarize;
    end
    // about fourteen times the expected run length
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        summarize;
    end
endmodule
`default_nettype wire
